// ### include/wut_pkg.sv
// wake-up timer package: register map, field layout, reset values, types
//
// Contract
// RQ1: running flag shows counting; permit gates change
// RQ2: running flag writes ignored without permit
// RQ3: auto-trim launches trimming at every underflow
// RQ4: software picks a proper trimming timer
// RQ5: auto card-detect runs detection; card raises interrupt
// RQ6: no card found returns to power-down
// RQ7: restart without gap; timer three times field
// RQ8: auto-reload reloads at zero, else stops
// RQ9: underflow sets the wake-up interrupt flag
// RQ10: auto-wake wakes system at every underflow
// RQ11: software sets auto-wake to re-enter power-down
// RQ12: clock select divides oscillator by 1/8/16/32
// RQ13: start event loads the 16-bit reload word
// RQ14: reload writes wait for next start event
// RQ15: counter value readable live as two bytes
// RQ16: timer reactivates system after programmed interval
// RQ17: each divided tick decrements; underflow from zero
`default_nettype none
package wut_pkg;

  // ==========================================================
  // register indices (byte address is four times the index)
  localparam int unsigned WUT_AW      = 8;
  localparam logic [5:0]  IDX_CTRL    = 6'h23;
  localparam logic [5:0]  IDX_RLD_HI  = 6'h24;
  localparam logic [5:0]  IDX_RLD_LO  = 6'h25;
  localparam logic [5:0]  IDX_CNT_HI  = 6'h26;
  localparam logic [5:0]  IDX_CNT_LO  = 6'h27;
  localparam logic [5:0]  IDX_STATUS  = 6'h30;
  localparam logic [5:0]  IDX_MASK    = 6'h31;

  // ==========================================================
  // control register bit positions
  localparam int unsigned CTL_RUN     = 7;
  localparam int unsigned CTL_PERMIT  = 6;
  localparam int unsigned CTL_TRIM    = 5;
  localparam int unsigned CTL_CARD    = 4;
  localparam int unsigned CTL_RELOAD  = 3;
  localparam int unsigned CTL_WAKE    = 2;
  localparam int unsigned CTL_CLK_HI  = 1;
  localparam int unsigned CTL_CLK_LO  = 0;

  // ==========================================================
  // status / mask bit positions
  localparam int unsigned ST_UNDER    = 0;
  localparam int unsigned ST_CARD     = 1;

  // ==========================================================
  // prescaler terminal counts for clock codes 0..3
  localparam logic [4:0]  DIV1_TERM   = 5'h00;
  localparam logic [4:0]  DIV8_TERM   = 5'h07;
  localparam logic [4:0]  DIV16_TERM  = 5'h0f;
  localparam logic [4:0]  DIV32_TERM  = 5'h1f;

  // ==========================================================
  // bus answers and reset values
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
  localparam logic [15:0] RELOAD_RST  = 16'h0000;
  localparam logic [15:0] COUNT_RST   = 16'h0000;

  // ==========================================================
  // types
  typedef enum logic [1:0] {
    WUT_WR_IDLE = 2'b00,
    WUT_WR_RESP = 2'b01
  } wut_wr_t;

  typedef enum logic [1:0] {
    WUT_PR_IDLE = 2'b00,
    WUT_PR_BUSY = 2'b01
  } wut_pr_t;

  typedef struct packed {
    logic       auto_trim_on_underflow;
    logic       auto_card_detect;
    logic       wakeup_auto_reload;
    logic       auto_wake_on_underflow;
    logic [1:0] wakeup_clock_select;
  } wut_cfg_t;

  typedef struct packed {
    logic       lfo_prev;
    logic [4:0] cnt;
    logic       tick;
  } wut_div_t;

  localparam wut_div_t WUT_DIV_RST = '0;

endpackage
`default_nettype wire

// ### rtl/wut_lfo_div.sv
// prescaler turning oscillator edges into counting ticks
`default_nettype none
module wut_lfo_div
  import wut_pkg::*;
(
  // clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // oscillator level and selection
  input  wire logic       lfo_clk_level,
  input  wire logic [1:0] clk_sel,
  input  wire logic       run,
  // one-cycle tick per divided period
  output logic            tick
);

  wut_div_t s_q;   // registered state
  wut_div_t s_d;   // next state
  logic [4:0] term; // terminal count for the selected divide

  // ==========================================================
  // divide selection
  always_comb begin
    case (clk_sel)
      2'b00:   term = DIV1_TERM;  // RQ12
      2'b01:   term = DIV8_TERM;  // RQ12
      2'b10:   term = DIV16_TERM; // RQ12
      default: term = DIV32_TERM; // RQ12
    endcase
  end

  // ==========================================================
  // edge counter; cleared while stopped so a start begins a full period
  always_comb begin
    s_d          = s_q;
    s_d.tick     = 1'b0;
    s_d.lfo_prev = lfo_clk_level;
    if (!run) begin
      s_d.cnt = 5'h00;
    end else if (lfo_clk_level && !s_q.lfo_prev) begin
      if (s_q.cnt >= term) begin
        s_d.cnt  = 5'h00;
        s_d.tick = 1'b1; // RQ17
      end else begin
        s_d.cnt = s_q.cnt + 5'h01;
      end
    end
  end

  // ==========================================================
  // state register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= WUT_DIV_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign tick = s_q.tick;

endmodule
`default_nettype wire

// ### rtl/wut_top.sv
// wake-up timer with card-detect trigger and AXI4-Lite register slave
//
// The AXI4-Lite register port was chosen for this implementation.
`default_nettype none
module wut_top
  import wut_pkg::*;
(
  // clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // axi4-lite write address
  input  wire logic [WUT_AW-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  // axi4-lite write response
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // axi4-lite read address
  input  wire logic [WUT_AW-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  // axi4-lite read data
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // low-frequency oscillator level
  input  wire logic              lfo_clk_level,
  // trimming and card-detection machinery
  output logic                   trim_start,
  input  wire logic              trim_done,
  output logic                   card_detect_start,
  input  wire logic              card_detect_done,
  input  wire logic              card_found,
  // power manager
  output logic                   wake_request,
  output logic                   power_down_request,
  // interrupt
  output logic                   irq
);

  // ==========================================================
  // state layout
  typedef struct packed {
    wut_wr_t     wr;         // write channel state
    logic        aw_have;    // write address held
    logic        w_have;     // write data held
    logic [5:0]  aw_idx;     // held write index
    logic [7:0]  w_byte;     // held low data byte
    logic        w_lane0;    // low byte lane enabled
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    wut_cfg_t    cfg;        // control options
    logic        running;    // wakeup_running_flag
    logic [15:0] reload;     // wakeup_reload_word
    logic [15:0] count;      // live down-counter
    logic [1:0]  status;     // sticky events
    logic [1:0]  mask;       // interrupt enables
    logic        irq;
    wut_pr_t     pr;         // procedure tracking state
    logic        pend_trim;  // trimming still running
    logic        pend_card;  // detection still running
    logic        card_seen;  // detection found a card
    logic        trim_start;
    logic        card_start;
    logic        wake_req;
    logic        pd_req;
  } wut_st_t;

  wut_st_t    s_q;        // registered state
  wut_st_t    s_d;        // next state
  logic       tick;       // divided oscillator tick
  logic [1:0] st_set;     // events this cycle
  logic [1:0] st_clr;     // status read this cycle
  logic [5:0] ar_idx;     // read index
  logic [7:0] rd_byte;    // decoded read byte
  logic       rd_hit;     // read index mapped

  // ==========================================================
  // prescaler runs only while counting
  wut_lfo_div u_div (
    .aclk          (aclk),
    .aresetn       (aresetn),
    .lfo_clk_level (lfo_clk_level),
    .clk_sel       (s_q.cfg.wakeup_clock_select),
    .run           (s_q.running),
    .tick          (tick)
  );

  assign ar_idx = s_axi_araddr[7:2];

  // ==========================================================
  // read decode; the permit bit is write-only and reads zero
  always_comb begin
    rd_byte = 8'h00;
    rd_hit  = 1'b1;
    case (ar_idx)
      IDX_CTRL: begin
        rd_byte = {s_q.running, 1'b0, s_q.cfg}; // RQ1
      end
      IDX_RLD_HI: begin
        rd_byte = s_q.reload[15:8];
      end
      IDX_RLD_LO: begin
        rd_byte = s_q.reload[7:0];
      end
      IDX_CNT_HI: begin
        rd_byte = s_q.count[15:8]; // RQ15
      end
      IDX_CNT_LO: begin
        rd_byte = s_q.count[7:0]; // RQ15
      end
      IDX_STATUS: begin
        rd_byte = {6'h00, s_q.status};
      end
      IDX_MASK: begin
        rd_byte = {6'h00, s_q.mask};
      end
      default: begin
        rd_hit = 1'b0; // unmapped answers slverr
      end
    endcase
  end

  // ==========================================================
  // next-state logic: procedures, timer, bus writes, bus reads
  always_comb begin
    s_d            = s_q;
    st_set         = 2'b00;
    st_clr         = 2'b00;
    s_d.trim_start = 1'b0;
    s_d.card_start = 1'b0;
    s_d.wake_req   = 1'b0;
    s_d.pd_req     = 1'b0;

    // procedure completion, checked before a new underflow re-arms it
    if (s_q.pr == WUT_PR_BUSY) begin
      if (trim_done) begin
        s_d.pend_trim = 1'b0;
      end
      if (card_detect_done) begin
        s_d.pend_card = 1'b0;
        if (card_found) begin
          s_d.card_seen    = 1'b1;
          st_set[ST_CARD] = 1'b1; // RQ5
        end
      end
      if (!s_d.pend_trim && !s_d.pend_card) begin
        s_d.pr = WUT_PR_IDLE;
        // auto-wake doubles as the return-to-sleep enable
        if (!s_d.card_seen && s_q.cfg.auto_wake_on_underflow) begin
          s_d.pd_req = 1'b1; // RQ6 RQ11
        end
      end
    end

    // down-counter; underflow is the tick taken at zero
    if (s_q.running && tick) begin
      if (s_q.count == 16'h0000) begin
        st_set[ST_UNDER] = 1'b1; // RQ9
        if (s_q.cfg.auto_wake_on_underflow) begin
          s_d.wake_req = 1'b1; // RQ10 RQ16
        end
        if (s_q.cfg.auto_trim_on_underflow) begin
          s_d.trim_start = 1'b1; // RQ3
          s_d.pend_trim  = 1'b1;
          s_d.card_seen  = 1'b0; // a fresh procedure forgets old finds
          s_d.pr         = WUT_PR_BUSY;
        end
        if (s_q.cfg.auto_card_detect) begin
          // starts timer three, which sets the field-on window
          s_d.card_start = 1'b1; // RQ5 RQ7
          s_d.pend_card  = 1'b1;
          s_d.card_seen  = 1'b0;
          s_d.pr         = WUT_PR_BUSY;
        end
        if (s_q.cfg.wakeup_auto_reload || s_q.cfg.auto_card_detect) begin
          s_d.count = s_q.reload; // RQ8 RQ7
        end else begin
          s_d.running = 1'b0; // RQ8
        end
      end else begin
        s_d.count = s_q.count - 16'h0001; // RQ17
      end
    end

    // write channel: address and data taken in either order
    case (s_q.wr)
      WUT_WR_IDLE: begin
        if (s_axi_awvalid && s_q.awready) begin
          s_d.aw_have = 1'b1;
          s_d.aw_idx  = s_axi_awaddr[7:2];
        end
        if (s_axi_wvalid && s_q.wready) begin
          s_d.w_have  = 1'b1;
          s_d.w_byte  = s_axi_wdata[7:0];
          s_d.w_lane0 = s_axi_wstrb[0];
        end
        if (s_d.aw_have && s_d.w_have) begin
          s_d.aw_have = 1'b0;
          s_d.w_have  = 1'b0;
          s_d.bvalid  = 1'b1;
          s_d.bresp   = RESP_OKAY;
          s_d.wr      = WUT_WR_RESP;
          // software write lands after the timer, so it wins
          case (s_d.aw_idx)
            IDX_CTRL: begin
              if (s_d.w_lane0) begin
                s_d.cfg = s_d.w_byte[CTL_TRIM:CTL_CLK_LO];
                if (s_d.w_byte[CTL_PERMIT]) begin
                  s_d.running = s_d.w_byte[CTL_RUN]; // RQ1 RQ2
                  if (s_d.w_byte[CTL_RUN]) begin
                    s_d.count = s_q.reload; // RQ13
                  end
                end
              end
            end
            IDX_RLD_HI: begin
              if (s_d.w_lane0) begin
                s_d.reload[15:8] = s_d.w_byte; // RQ14
              end
            end
            IDX_RLD_LO: begin
              if (s_d.w_lane0) begin
                s_d.reload[7:0] = s_d.w_byte; // RQ14
              end
            end
            IDX_MASK: begin
              if (s_d.w_lane0) begin
                s_d.mask = s_d.w_byte[1:0];
              end
            end
            IDX_CNT_HI, IDX_CNT_LO, IDX_STATUS: begin
              s_d.bresp = RESP_OKAY; // read-only, write dropped
            end
            default: begin
              s_d.bresp = RESP_SLVERR;
            end
          endcase
        end
      end
      WUT_WR_RESP: begin
        if (s_axi_bready) begin
          s_d.bvalid = 1'b0;
          s_d.wr     = WUT_WR_IDLE;
        end
      end
      default: begin
        s_d.wr     = WUT_WR_IDLE;
        s_d.bvalid = 1'b0;
      end
    endcase
    s_d.awready = (s_d.wr == WUT_WR_IDLE) && !s_d.aw_have;
    s_d.wready  = (s_d.wr == WUT_WR_IDLE) && !s_d.w_have;

    // read channel: one outstanding read, answered next cycle
    if (s_q.rvalid) begin
      if (s_axi_rready) begin
        s_d.rvalid = 1'b0;
      end
    end else if (s_axi_arvalid && s_q.arready) begin
      s_d.rvalid = 1'b1;
      s_d.rdata  = {24'h00_0000, rd_byte};
      s_d.rresp  = rd_hit ? RESP_OKAY : RESP_SLVERR;
      if (ar_idx == IDX_STATUS) begin
        st_clr = 2'b11; // read clears the status
      end
    end
    s_d.arready = !s_d.rvalid;

    // sticky status: an event in the clearing cycle survives
    s_d.status = (s_q.status & ~st_clr) | st_set;
    s_d.irq    = |(s_d.status & s_d.mask);
  end

  // ==========================================================
  // state register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================
  // outputs straight from the state register
  assign s_axi_awready      = s_q.awready;
  assign s_axi_wready       = s_q.wready;
  assign s_axi_bresp        = s_q.bresp;
  assign s_axi_bvalid       = s_q.bvalid;
  assign s_axi_arready      = s_q.arready;
  assign s_axi_rdata        = s_q.rdata;
  assign s_axi_rresp        = s_q.rresp;
  assign s_axi_rvalid       = s_q.rvalid;
  assign trim_start         = s_q.trim_start;
  assign card_detect_start  = s_q.card_start;
  assign wake_request       = s_q.wake_req;
  assign power_down_request = s_q.pd_req;
  assign irq                = s_q.irq;

endmodule
`default_nettype wire

// ### verification/wut_properties.sv
// port-level checker for the wake-up timer block
`default_nettype none
module wut_properties (
  // clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // register bus handshakes
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  // event pulses
  input wire logic        wake_request,
  input wire logic        trim_start,
  input wire logic        card_detect_start,
  input wire logic        power_down_request
);
  // ==========================================================
  // one clock domain, reset disables everything
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // both write halves taken at one edge
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence

  property p_b_after; s_wr_taken |=> s_axi_bvalid; endproperty
  property p_r_after; s_rd_taken |=> s_axi_rvalid ##0 !s_axi_arready; endproperty
  // an answer stays exactly until it is accepted, its payload unchanged
  property p_b_hold;
    s_axi_bvalid |=> (s_axi_bvalid != $past(s_axi_bready))
      && ($stable(s_axi_bresp) || !s_axi_bvalid);
  endproperty
  property p_r_hold;
    s_axi_rvalid |=> (s_axi_rvalid != $past(s_axi_rready))
      && ($stable(s_axi_rdata) || !s_axi_rvalid);
  endproperty
  property p_b_close; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
  property p_r_close; s_axi_rvalid |-> !s_axi_arready; endproperty
  property p_rdata_byte; s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000; endproperty
  property p_wake_pulse; wake_request |=> !wake_request; endproperty
  property p_trim_pulse; trim_start |=> !trim_start; endproperty
  property p_cd_pulse; card_detect_start |=> !card_detect_start; endproperty
  property p_pd_pulse; power_down_request |=> !power_down_request; endproperty

  a_b_after: assert property (p_b_after) else $error("no write response");
  a_r_after: assert property (p_r_after) else $error("no read answer");
  a_b_hold: assert property (p_b_hold) else $error("write response dropped");
  a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
  a_b_close: assert property (p_b_close) else $error("write taken during response");
  a_r_close: assert property (p_r_close) else $error("read taken during answer");
  a_rdata_byte: assert property (p_rdata_byte) else $error("upper read bits set");
  a_wake_pulse: assert property (p_wake_pulse) else $error("wake pulse too long");
  a_trim_pulse: assert property (p_trim_pulse) else $error("trim pulse too long");
  a_cd_pulse: assert property (p_cd_pulse) else $error("detect pulse too long");
  a_pd_pulse: assert property (p_pd_pulse) else $error("sleep pulse too long");
endmodule
`default_nettype wire

// ### verification/wut_top_tb.sv
// self-checking bench for the wake-up timer over its register bus
`default_nettype none
module wut_top_tb
  import wut_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // stimulus and observed signals
  logic [WUT_AW-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0]       s_axi_wdata = '0, s_axi_rdata;
  logic [3:0]        s_axi_wstrb = '0;
  logic [1:0]        s_axi_bresp, s_axi_rresp, last_resp;
  logic              aclk = 1'b0, aresetn = 1'b0, lfo_clk_level = 1'b0;
  logic              s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic              s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic              trim_done = 1'b0, card_detect_done = 1'b0, card_found = 1'b0;
  logic              s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic              trim_start, card_detect_start, wake_request, power_down_request, irq;
  int                failures = 0, check_count = 0, cyc = 0;
  int                n_wake = 0, n_trim = 0, n_cd = 0, n_pd = 0;
  int                divs [4] = '{1, 8, 16, 32};

  wut_top wut_top_inst (
    .aclk(aclk), .aresetn(aresetn), .lfo_clk_level(lfo_clk_level), .irq(irq),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .trim_start(trim_start),
    .trim_done(trim_done), .card_detect_start(card_detect_start),
    .card_detect_done(card_detect_done), .card_found(card_found),
    .wake_request(wake_request), .power_down_request(power_down_request)
  );

  always #2 aclk = ~aclk;

  // pulse tallies and hang guard; budget is far above the real run
  always @(posedge aclk) begin
    cyc++;
    n_wake += int'(wake_request === 1'b1);
    n_trim += int'(trim_start === 1'b1);
    n_cd += int'(card_detect_start === 1'b1);
    n_pd += int'(power_down_request === 1'b1);
    if (cyc == 40000) begin
      failures++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("checks=%0d mismatches=%0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // write: address and data offered together, each dropped once taken
  task automatic wr(input logic [5:0] idx, input logic [7:0] d);
    @(posedge aclk);
    s_axi_awaddr <= {idx, 2'b00};
    s_axi_wdata <= {24'h00_0000, d};
    s_axi_wstrb <= 4'h1;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    last_resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  // read and compare the low byte; upper bits must be zero
  task automatic rd(input logic [5:0] idx, input logic [7:0] exp);
    @(posedge aclk);
    s_axi_araddr <= {idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    last_resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, {24'h00_0000, exp});
  endtask

  // n oscillator rising edges, two cycles per level, then settle
  task automatic lfo(input int n);
    repeat (n) begin
      @(posedge aclk) lfo_clk_level <= 1'b1;
      repeat (2) @(posedge aclk);
      lfo_clk_level <= 1'b0;
      @(posedge aclk);
    end
    repeat (4) @(posedge aclk);
  endtask

  // finish trimming, then detection with the given outcome
  task automatic done(input logic found);
    @(posedge aclk) trim_done <= 1'b1;
    @(posedge aclk) trim_done <= 1'b0;
    card_detect_done <= 1'b1;
    card_found <= found;
    @(posedge aclk) card_detect_done <= 1'b0;
    card_found <= 1'b0;
    repeat (4) @(posedge aclk);
  endtask

  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    rd(IDX_CTRL, 8'h00);
    chk(32'(last_resp), 32'(RESP_OKAY));
    rd(IDX_RLD_HI, 8'h00);
    rd(IDX_RLD_LO, 8'h00);
    rd(IDX_CNT_HI, 8'h00);
    rd(IDX_STATUS, 8'h00);
    rd(6'h01, 8'h00);
    chk(32'(last_resp), 32'(RESP_SLVERR));
    wr(6'h01, 8'h00);
    chk(32'(last_resp), 32'(RESP_SLVERR));
    wr(IDX_CNT_LO, 8'h5A);
    chk(32'(last_resp), 32'(RESP_OKAY));
    rd(IDX_CNT_LO, 8'h00);
    wr(IDX_CTRL, 8'h80);
    rd(IDX_CTRL, 8'h00);
    $display("test reset and access done");
    wr(IDX_RLD_LO, 8'h03);
    wr(IDX_MASK, 8'h01);
    wr(IDX_CTRL, 8'hCC);
    rd(IDX_CTRL, 8'h8C);
    rd(IDX_CNT_LO, 8'h03);
    wr(IDX_RLD_LO, 8'h05);
    rd(IDX_CNT_LO, 8'h03);
    wr(IDX_RLD_LO, 8'h03);
    lfo(2);
    rd(IDX_CNT_LO, 8'h01);
    lfo(2);
    rd(IDX_CNT_LO, 8'h03);
    chk(32'(irq), 32'h0000_0001);
    chk(n_wake, 1);
    rd(IDX_STATUS, 8'h01);
    rd(IDX_STATUS, 8'h00);
    repeat (2) @(posedge aclk);
    chk(32'(irq), 32'h0000_0000);
    $display("test reload and interrupt done");
    wr(IDX_MASK, 8'h00);
    wr(IDX_CTRL, 8'hF4);
    lfo(4);
    chk(n_trim, 1);
    chk(n_cd, 1);
    rd(IDX_CNT_LO, 8'h03);
    chk(32'(irq), 32'h0000_0000);
    done(1'b0);
    chk(n_pd, 1);
    lfo(4);
    done(1'b1);
    chk(n_pd, 1);
    wr(IDX_MASK, 8'h02);
    repeat (2) @(posedge aclk);
    chk(32'(irq), 32'h0000_0001);
    rd(IDX_STATUS, 8'h03);
    wr(IDX_CTRL, 8'hE4);
    lfo(4);
    chk(n_trim, 3);
    done(1'b0);
    chk(n_pd, 2);
    $display("test trim and detection done");
    wr(IDX_CTRL, 8'hC0);
    lfo(4);
    rd(IDX_CTRL, 8'h00);
    rd(IDX_CNT_LO, 8'h00);
    wr(IDX_RLD_LO, 8'h10);
    foreach (divs[c]) begin
      wr(IDX_CTRL, 8'h40);
      wr(IDX_CTRL, 8'hC0 | 8'(c));
      lfo(divs[c] - 1);
      rd(IDX_CNT_LO, 8'h10);
      lfo(1);
      rd(IDX_CNT_LO, 8'h0F);
    end
    wr(IDX_CTRL, 8'h40);
    rd(IDX_CTRL, 8'h00);
    $display("test stop and divide done");
    wrap_up();
  end
endmodule

bind wut_top wut_properties wut_properties_inst (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .wake_request, .trim_start,
  .card_detect_start, .power_down_request
);
`default_nettype wire
